// ### rtl/wtr_pkg.sv
package wtr_pkg;
    localparam int RES_W = 12;
    localparam int HYS_W = 6;
    localparam int EVT_W = 4;
    localparam int NUM_CH = 2;
    localparam int NUM_REGS = 10;
    // byte offsets of the threshold bank
    localparam logic [7:0] CH0_UPPER_LOW_OFS = 8'h38;
    localparam logic [7:0] CH0_UPPER_HIGH_OFS = 8'h39;
    localparam logic [7:0] CH0_LOWER_LOW_OFS = 8'h3A;
    localparam logic [7:0] CH0_LOWER_HIGH_OFS = 8'h3B;
    localparam logic [7:0] CH1_UPPER_LOW_OFS = 8'h3C;
    localparam logic [7:0] CH1_UPPER_HIGH_OFS = 8'h3D;
    localparam logic [7:0] CH1_LOWER_LOW_OFS = 8'h3E;
    localparam logic [7:0] CH1_LOWER_HIGH_OFS = 8'h3F;
    localparam logic [7:0] CH0_HYST_OFS = 8'h40;
    localparam logic [7:0] CH1_HYST_OFS = 8'h41;
    localparam logic [7:0] BANK_FIRST_OFS = CH0_UPPER_LOW_OFS;
    localparam logic [7:0] BANK_LAST_OFS = CH1_HYST_OFS;
    // bank index layout: per channel four bytes, hysteresis after them
    localparam int IDX_PER_CH = 4;
    localparam int IDX_UPPER_LOW = 0;
    localparam int IDX_UPPER_HIGH = 1;
    localparam int IDX_LOWER_LOW = 2;
    localparam int IDX_LOWER_HIGH = 3;
    localparam int IDX_HYST_BASE = 8;
    // writable field masks, the rest reads zero
    localparam logic [7:0] LOW_PART_MASK = 8'hFF;
    localparam logic [7:0] HIGH_PART_MASK = 8'h0F;
    localparam logic [7:0] HYST_MASK = 8'h3F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : wtr_pkg

// ### rtl/wtr_chan_cmp.sv
`timescale 1ns/1ns
module wtr_chan_cmp #(
    parameter int RES_W = 12,
    parameter int HYS_W = 6,
    parameter int EVT_W = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] sample,
    input wire logic [RES_W-1:0] upper_limit,
    input wire logic [RES_W-1:0] lower_limit,
    input wire logic [HYS_W-1:0] hysteresis,
    input wire logic [EVT_W-1:0] consecutive_event_count,
    output logic upper_hit,
    output logic lower_hit,
    output logic alert
);
    localparam logic [RES_W-1:0] RES_MAX = {RES_W{1'b1}};

    logic [EVT_W:0] run;
    logic [EVT_W:0] next_run;
    logic next_upper_hit;
    logic next_lower_hit;
    logic next_alert;
    logic [RES_W-1:0] hys_ext;
    logic [RES_W-1:0] upper_release;
    logic [RES_W:0] lower_sum;
    logic [RES_W-1:0] lower_release;
    logic [EVT_W:0] needed;

    always_comb begin
        hys_ext = RES_W'(hysteresis);
        // release points saturate so a large hysteresis cannot wrap around the code range
        upper_release = (upper_limit > hys_ext) ? upper_limit - hys_ext : '0;
        lower_sum = {1'b0, lower_limit} + {1'b0, hys_ext};
        lower_release = lower_sum[RES_W] ? RES_MAX : lower_sum[RES_W-1:0];
        needed = {1'b0, consecutive_event_count} + (EVT_W+1)'(1);
        next_upper_hit = upper_hit;
        next_lower_hit = lower_hit;
        next_run = run;
        next_alert = alert;
        if (sample_valid) begin
            // set at the limit, hold until the sample leaves the hysteresis band
            next_upper_hit = upper_hit ? (sample >= upper_release) : (sample >= upper_limit);
            next_lower_hit = lower_hit ? (sample <= lower_release) : (sample <= lower_limit);
            if (next_upper_hit || next_lower_hit) begin
                // clamp to the current need so a lowered count cannot leave the run above it
                next_run = (run >= needed) ? needed : run + (EVT_W+1)'(1);
            end else begin
                next_run = '0;
            end
            next_alert = (next_run >= needed);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_hit <= 1'b0;
            lower_hit <= 1'b0;
            run <= '0;
            alert <= 1'b0;
        end else begin
            upper_hit <= next_upper_hit;
            lower_hit <= next_lower_hit;
            run <= next_run;
            alert <= next_alert;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_upper_set;
        sample_valid && (sample >= upper_limit) |=> upper_hit;
    endproperty
    a_upper_set: assert property (p_upper_set) else $error("upper hit missing at limit");

    property p_lower_set;
        sample_valid && (sample <= lower_limit) |=> lower_hit;
    endproperty
    a_lower_set: assert property (p_lower_set) else $error("lower hit missing at limit");

    property p_alert_needs_run;
        $rose(alert) |-> (run == needed) && (upper_hit || lower_hit);
    endproperty
    a_alert_needs_run: assert property (p_alert_needs_run) else $error("alert without enough events");

    property p_single_event;
        sample_valid && (consecutive_event_count == '0) && (sample >= upper_limit) |=> alert;
    endproperty
    a_single_event: assert property (p_single_event) else $error("count zero must alert on first event");

    property p_clear_on_quiet;
        sample_valid && !next_upper_hit && !next_lower_hit |=> !alert ##0 (run == '0);
    endproperty
    a_clear_on_quiet: assert property (p_clear_on_quiet) else $error("alert held after quiet sample");

    c_alert: cover property ($rose(alert));
    c_hys_hold: cover property (upper_hit && sample_valid && (sample < upper_limit) ##1 upper_hit);
endmodule : wtr_chan_cmp

// ### rtl/wtr_top.sv
`timescale 1ns/1ns
// Operation
// - ch0 upper limit, low byte plus nibble
// - ch0 lower limit, low byte plus nibble
// - ch1 upper limit, low byte plus nibble
// - ch1 lower limit, low byte plus nibble
// - ch0 hysteresis serves both ch0 comparators
// - ch1 hysteresis serves both ch1 comparators
// - unused upper bits read as zero
// - reset clears all limits and hysteresis
// - lower hit when result at or below limit
// - upper hit when result at or above limit
// - alert only after consecutive hit conversions
// - needed conversions equal event count plus one
module wtr_top #(
    parameter int RES_W = wtr_pkg::RES_W,
    parameter int HYS_W = wtr_pkg::HYS_W,
    parameter int EVT_W = wtr_pkg::EVT_W
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic conv_valid,
    input wire logic conv_chan,
    input wire logic [RES_W-1:0] conv_result,
    input wire logic [EVT_W-1:0] consecutive_event_count,
    output logic [wtr_pkg::NUM_CH-1:0] upper_hit,
    output logic [wtr_pkg::NUM_CH-1:0] lower_hit,
    output logic [wtr_pkg::NUM_CH-1:0] alert
);
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [7:0] bank [wtr_pkg::NUM_REGS];
    logic [7:0] next_bank [wtr_pkg::NUM_REGS];
    logic [7:0] next_rdata;
    logic [RES_W-1:0] upper_limit [wtr_pkg::NUM_CH];
    logic [RES_W-1:0] lower_limit [wtr_pkg::NUM_CH];
    logic [HYS_W-1:0] hysteresis [wtr_pkg::NUM_CH];

    function automatic logic bank_hit(input logic [7:0] addr);
        return (addr >= wtr_pkg::BANK_FIRST_OFS) && (addr <= wtr_pkg::BANK_LAST_OFS);
    endfunction : bank_hit

    function automatic logic [3:0] bank_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - wtr_pkg::BANK_FIRST_OFS;
        return diff[3:0];
    endfunction : bank_index

    function automatic logic [7:0] field_mask(input logic [3:0] idx);
        if (idx >= 4'(wtr_pkg::IDX_HYST_BASE)) begin
            return wtr_pkg::HYST_MASK;
        end else if (idx[0]) begin
            return wtr_pkg::HIGH_PART_MASK;
        end
        return wtr_pkg::LOW_PART_MASK;
    endfunction : field_mask

    // reset is asserted at once but released only after two clean edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_comb begin
        next_bank = bank;
        next_rdata = reg_rdata;
        if (reg_wr && bank_hit(reg_addr)) begin
            // masking on write keeps the unused bits at zero for every later read
            next_bank[bank_index(reg_addr)] = reg_wdata & field_mask(bank_index(reg_addr));
        end
        if (reg_rd) begin
            next_rdata = bank_hit(reg_addr) ? bank[bank_index(reg_addr)] : wtr_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < wtr_pkg::NUM_REGS; i++) begin
                bank[i] <= wtr_pkg::REG_RESET;
            end
            reg_rdata <= wtr_pkg::UNMAPPED_READ;
        end else begin
            bank <= next_bank;
            reg_rdata <= next_rdata;
        end
    end

    for (genvar ch = 0; ch < wtr_pkg::NUM_CH; ch++) begin : g_ch
        localparam int B = ch * wtr_pkg::IDX_PER_CH;
        // limits follow the stored bytes directly; a split update is seen half-written until its second byte is written
        assign upper_limit[ch] = {bank[B + wtr_pkg::IDX_UPPER_HIGH][3:0],
                                  bank[B + wtr_pkg::IDX_UPPER_LOW]};
        assign lower_limit[ch] = {bank[B + wtr_pkg::IDX_LOWER_HIGH][3:0],
                                  bank[B + wtr_pkg::IDX_LOWER_LOW]};
        assign hysteresis[ch] = bank[wtr_pkg::IDX_HYST_BASE + ch][HYS_W-1:0];

        wtr_chan_cmp #(
            .RES_W(RES_W),
            .HYS_W(HYS_W),
            .EVT_W(EVT_W)
        ) u_cmp (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .sample_valid(conv_valid && (conv_chan == 1'(ch))),
            .sample(conv_result),
            .upper_limit(upper_limit[ch]),
            .lower_limit(lower_limit[ch]),
            .hysteresis(hysteresis[ch]),
            .consecutive_event_count(consecutive_event_count),
            .upper_hit(upper_hit[ch]),
            .lower_hit(lower_hit[ch]),
            .alert(alert[ch])
        );
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ch0_upper_low;
        reg_wr && (reg_addr == wtr_pkg::CH0_UPPER_LOW_OFS) |=> upper_limit[0][7:0] == $past(reg_wdata);
    endproperty
    a_ch0_upper_low: assert property (p_ch0_upper_low) else $error("ch0 upper low byte not stored");

    property p_ch0_lower_high;
        reg_wr && (reg_addr == wtr_pkg::CH0_LOWER_HIGH_OFS) |=> lower_limit[0][11:8] == $past(reg_wdata[3:0]);
    endproperty
    a_ch0_lower_high: assert property (p_ch0_lower_high) else $error("ch0 lower nibble not stored");

    property p_ch1_upper_high;
        reg_wr && (reg_addr == wtr_pkg::CH1_UPPER_HIGH_OFS) |=> upper_limit[1][11:8] == $past(reg_wdata[3:0]);
    endproperty
    a_ch1_upper_high: assert property (p_ch1_upper_high) else $error("ch1 upper nibble not stored");

    property p_ch1_lower_low;
        reg_wr && (reg_addr == wtr_pkg::CH1_LOWER_LOW_OFS) |=> lower_limit[1][7:0] == $past(reg_wdata);
    endproperty
    a_ch1_lower_low: assert property (p_ch1_lower_low) else $error("ch1 lower low byte not stored");

    property p_ch0_hyst;
        reg_wr && (reg_addr == wtr_pkg::CH0_HYST_OFS) |=> hysteresis[0] == $past(reg_wdata[5:0]);
    endproperty
    a_ch0_hyst: assert property (p_ch0_hyst) else $error("ch0 hysteresis not stored");

    property p_ch1_hyst_read;
        reg_wr && (reg_addr == wtr_pkg::CH1_HYST_OFS) ##1 !reg_wr ##1 reg_rd && (reg_addr == wtr_pkg::CH1_HYST_OFS)
            |=> reg_rdata == ($past(reg_wdata, 3) & wtr_pkg::HYST_MASK);
    endproperty
    a_ch1_hyst_read: assert property (p_ch1_hyst_read) else $error("ch1 hysteresis readback wrong");

    property p_reserved_zero;
        reg_rd && bank_hit(reg_addr) && (bank_index(reg_addr) >= 4'(wtr_pkg::IDX_HYST_BASE))
            |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved hysteresis bits not zero");

    property p_nibble_zero;
        reg_rd && bank_hit(reg_addr) && (bank_index(reg_addr) < 4'(wtr_pkg::IDX_HYST_BASE)) && reg_addr[0]
            |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_nibble_zero: assert property (p_nibble_zero) else $error("reserved nibble bits not zero");

    property p_reset_zero;
        $rose(rst_n) |-> (upper_limit[0] == '0) && (lower_limit[1] == '0) && (hysteresis[0] == '0)
            && (hysteresis[1] == '0) && (reg_rdata == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("bank not zero after reset");

    property p_no_shadow;
        reg_wr && (reg_addr == wtr_pkg::CH0_UPPER_HIGH_OFS) |=> upper_limit[0][7:0] == $past(upper_limit[0][7:0]);
    endproperty
    a_no_shadow: assert property (p_no_shadow) else $error("low byte disturbed by high write");

    property p_ch0_upper_high;
        reg_wr && (reg_addr == wtr_pkg::CH0_UPPER_HIGH_OFS) |=> upper_limit[0][11:8] == $past(reg_wdata[3:0]);
    endproperty
    a_ch0_upper_high: assert property (p_ch0_upper_high) else $error("ch0 upper nibble not stored");

    property p_ch0_lower_low;
        reg_wr && (reg_addr == wtr_pkg::CH0_LOWER_LOW_OFS) |=> lower_limit[0][7:0] == $past(reg_wdata);
    endproperty
    a_ch0_lower_low: assert property (p_ch0_lower_low) else $error("ch0 lower low byte not stored");

    property p_ch1_upper_low;
        reg_wr && (reg_addr == wtr_pkg::CH1_UPPER_LOW_OFS) |=> upper_limit[1][7:0] == $past(reg_wdata);
    endproperty
    a_ch1_upper_low: assert property (p_ch1_upper_low) else $error("ch1 upper low byte not stored");

    property p_ch1_lower_high;
        reg_wr && (reg_addr == wtr_pkg::CH1_LOWER_HIGH_OFS) |=> lower_limit[1][11:8] == $past(reg_wdata[3:0]);
    endproperty
    a_ch1_lower_high: assert property (p_ch1_lower_high) else $error("ch1 lower nibble not stored");

    property p_ch1_hyst;
        reg_wr && (reg_addr == wtr_pkg::CH1_HYST_OFS) |=> hysteresis[1] == $past(reg_wdata[5:0]);
    endproperty
    a_ch1_hyst: assert property (p_ch1_hyst) else $error("ch1 hysteresis not stored");

    property p_ch0_upper_low_read;
        reg_rd && (reg_addr == wtr_pkg::CH0_UPPER_LOW_OFS) |=> reg_rdata == $past(upper_limit[0][7:0]);
    endproperty
    a_ch0_upper_low_read: assert property (p_ch0_upper_low_read) else $error("ch0 upper low byte readback wrong");

    property p_ch1_lower_high_read;
        reg_rd && (reg_addr == wtr_pkg::CH1_LOWER_HIGH_OFS) |=> reg_rdata == {4'h0, $past(lower_limit[1][11:8])};
    endproperty
    a_ch1_lower_high_read: assert property (p_ch1_lower_high_read) else $error("ch1 lower nibble readback wrong");

    property p_ch1_low_no_shadow;
        reg_wr && (reg_addr == wtr_pkg::CH1_UPPER_LOW_OFS) |=> upper_limit[1][11:8] == $past(upper_limit[1][11:8]);
    endproperty
    a_ch1_low_no_shadow: assert property (p_ch1_low_no_shadow) else $error("high part disturbed by low write");

    c_write_read: cover property (reg_wr && bank_hit(reg_addr) ##2 reg_rd);
    c_ch1_alert: cover property ($rose(alert[1]));
    c_unmapped: cover property (reg_rd && !bank_hit(reg_addr));
endmodule : wtr_top

// ### tb/wtr_host_model.sv
`timescale 1ns/1ns
module wtr_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    output logic conv_valid,
    output logic conv_chan,
    output logic [wtr_pkg::RES_W-1:0] conv_result
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        conv_valid = 1'b0;
        conv_chan = 1'b0;
        conv_result = 12'h000;
    end

    // released lines show the inverse, so a stale value can never pass as live
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : reg_read

    // returns one and a half cycles after the taking edge so the outputs have landed
    task automatic convert(input logic ch, input logic [wtr_pkg::RES_W-1:0] r);
        @(negedge core_clk);
        conv_chan = ch;
        conv_result = r;
        conv_valid = 1'b1;
        @(negedge core_clk);
        conv_valid = 1'b0;
        conv_chan = ~ch;
        conv_result = ~r;
        @(negedge core_clk);
    endtask : convert
endmodule : wtr_host_model

// ### tb/wtr_top_tb_top.sv
`timescale 1ns/1ns
module wtr_top_tb_top;
    logic core_clk;
    logic arst_n;
    logic [3:0] consecutive_event_count;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, conv_valid, conv_chan;
    logic [wtr_pkg::RES_W-1:0] conv_result;
    logic [1:0] upper_hit, lower_hit, alert;
    int errors;
    int n_compared;
    logic [7:0] msk [10] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h3F, 8'h3F};

    wtr_top DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_result(conv_result), .consecutive_event_count(consecutive_event_count),
        .upper_hit(upper_hit), .lower_hit(lower_hit), .alert(alert));

    wtr_host_model u_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .conv_valid(conv_valid),
        .conv_chan(conv_chan), .conv_result(conv_result));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.reg_read(a, d);
        check({4'h0, d}, {4'h0, e});
    endtask : rd_chk

    task automatic cv(input logic ch, input logic [11:0] r, input logic eu, input logic el, input logic ea);
        u_host.convert(ch, r);
        check({9'h000, upper_hit[ch], lower_hit[ch], alert[ch]}, {9'h000, eu, el, ea});
    endtask : cv

    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        consecutive_event_count = 4'h0;
        errors = 0;
        n_compared = 0;
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 10; i++) rd_chk(8'h38 + 8'(i), 8'h00);
        rd_chk(8'h37, 8'h00);
        for (int i = 0; i < 10; i++) u_host.reg_write(8'h38 + 8'(i), 8'hFF);
        for (int i = 0; i < 10; i++) rd_chk(8'h38 + 8'(i), msk[i]);
        u_host.reg_write(8'h42, 8'hFF);
        rd_chk(8'h42, 8'h00);
        for (int i = 0; i < 10; i++) u_host.reg_write(8'h38 + 8'(i), 8'h00);
        // upper nibble written with junk on top to prove it never reaches the limit
        u_host.reg_write(8'h38, 8'h23);
        u_host.reg_write(8'h39, 8'hF1);
        u_host.reg_write(8'h3A, 8'h45);
        cv(1'b0, 12'h123, 1'b1, 1'b0, 1'b1);
        cv(1'b0, 12'h122, 1'b0, 1'b0, 1'b0);
        cv(1'b0, 12'h045, 1'b0, 1'b1, 1'b1);
        cv(1'b0, 12'h046, 1'b0, 1'b0, 1'b0);
        u_host.reg_write(8'h40, 8'hC4);
        cv(1'b0, 12'h123, 1'b1, 1'b0, 1'b1);
        cv(1'b0, 12'h11F, 1'b1, 1'b0, 1'b1);
        cv(1'b0, 12'h11E, 1'b0, 1'b0, 1'b0);
        cv(1'b0, 12'h045, 1'b0, 1'b1, 1'b1);
        cv(1'b0, 12'h049, 1'b0, 1'b1, 1'b1);
        cv(1'b0, 12'h04A, 1'b0, 1'b0, 1'b0);
        u_host.reg_write(8'h38, 8'h10);
        cv(1'b0, 12'h110, 1'b1, 1'b0, 1'b1);
        u_host.reg_write(8'h3D, 8'h08);
        u_host.reg_write(8'h3F, 8'h01);
        consecutive_event_count = 4'h2;
        cv(1'b1, 12'h900, 1'b1, 1'b0, 1'b0);
        cv(1'b1, 12'h900, 1'b1, 1'b0, 1'b0);
        cv(1'b0, 12'h080, 1'b0, 1'b0, 1'b0);
        cv(1'b1, 12'h900, 1'b1, 1'b0, 1'b1);
        cv(1'b1, 12'h7FF, 1'b0, 1'b0, 1'b0);
        cv(1'b1, 12'h0FF, 1'b0, 1'b1, 1'b0);
        cv(1'b1, 12'h100, 1'b0, 1'b1, 1'b0);
        cv(1'b1, 12'h101, 1'b0, 1'b0, 1'b0);
        u_host.reg_write(8'h41, 8'hC2);
        rd_chk(8'h41, 8'h02);
        cv(1'b1, 12'h800, 1'b1, 1'b0, 1'b0);
        cv(1'b1, 12'h7FE, 1'b1, 1'b0, 1'b0);
        cv(1'b1, 12'h7FD, 1'b0, 1'b0, 1'b0);
        consecutive_event_count = 4'h0;
        cv(1'b1, 12'h800, 1'b1, 1'b0, 1'b1);
        end_of_test();
    end
endmodule : wtr_top_tb_top
